// ### dv/eight_bit_timer_interval_capture_pwm_bench.sv
// Self-checking bench of the timer core against an integer model.
`timescale 1ns/1ns
`default_nettype none
module eight_bit_timer_interval_capture_pwm_bench;
   import timer8_pkg::*;
   logic clk_sys, rstn, reg_wr, reg_rd, capture_edge_input, external_count_clock;
   logic compare_toggle_output, pulse_mod_output, count_wrap_interrupt, match_capture_interrupt;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v, ovf_v;
   logic [31:0] lf;
   logic [7:0] ra[4] = '{ADDR_MODE_CTRL, ADDR_CMP_CAP, ADDR_IRQ_PEND, 8'hF0};
   logic [7:0] re[4] = '{MODE_CTRL_RST, CMP_CAP_RST, ZERO8, ZERO8};
   int err_total = 0, comparisons = 0, cyc = 0, cnt = 0, rv = 0, tog = 0, pend = 0, md = 0, dv = 0, k = 0;
   timer8 i_dut (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .external_count_clock,
      .capture_edge_input, .compare_toggle_output, .pulse_mod_output, .count_wrap_interrupt,
      .match_capture_interrupt, .ovf_vector(ovf_v));
   ext_pulse_source i_src (.clk_sys, .ext_clk(external_count_clock));
   // System clock at 20 MHz.
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t reg %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_pin(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t pin %b exp %b", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 rd_v = reg_rdata;
   endtask
   // Model: one step per counter clock; interval match clears, the top value wraps.
   task automatic run(input int n);
      i_src.pulses(n);
      repeat (n) begin
         if (md == 0 && cnt == rv) begin
            cnt = 0;
            tog ^= 1;
            pend |= 1;
         end else begin
            if (cnt == 255) pend |= 2;
            cnt = (cnt + 1) % 256;
         end
      end
      repeat (8) @(posedge clk_sys);
      #1;
   endtask
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Hang guard.
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 30000) begin
         err_total++;
         report_and_stop;
      end
   end
   // Main sequence.
   initial begin
      {rstn, reg_wr, reg_rd, capture_edge_input} = 4'h0;
      reg_addr = ZERO8;
      reg_wdata = ZERO8;
      lf = 32'hCFFB9306;
      repeat (5) @(posedge clk_sys);
      rstn <= 1'b1;
      foreach (ra[i]) begin
         rd(ra[i]);
         cmp_reg(rd_v, re[i]);
      end
      cmp_reg(ovf_v, 8'h00);
      lf = lfsr(lf);
      wr(ADDR_MODE_CTRL, lf[7:0] & 8'hF6);
      rd(ADDR_MODE_CTRL);
      cmp_reg(rd_v, lf[7:0] & 8'hF6);
      wr(ADDR_COUNT, lf[15:8]);
      rd(ADDR_COUNT);
      cmp_reg(rd_v, ZERO8);
      // Interval mode on the external clock, one match then one more step.
      rv = lf[18:16] + 2;
      wr(ADDR_CMP_CAP, 8'(rv));
      wr(ADDR_MODE_CTRL, 8'hCB);
      run(rv + 2);
      rd(ADDR_COUNT);
      cmp_reg(rd_v, 8'(cnt));
      cmp_pin(compare_toggle_output, tog[0]);
      cmp_pin(match_capture_interrupt, pend[0]);
      wr(ADDR_MODE_CTRL, 8'hC1);
      cmp_pin(match_capture_interrupt, 1'b0);
      wr(ADDR_IRQ_PEND, ZERO8);
      wr(ADDR_MODE_CTRL, 8'hC3);
      cmp_pin(match_capture_interrupt, 1'b0);
      wr(ADDR_MODE_CTRL, 8'hCB);
      rd(ADDR_COUNT);
      cmp_reg(rd_v, ZERO8);
      // Prescaled clocks: a run of k whole divider periods gives exactly k steps.
      wr(ADDR_CMP_CAP, COUNT_MAX);
      for (int s = 0; s < 3; s++) begin
         lf = lfsr(lf);
         k = lf[1:0] + 1;
         dv = 1024 >> (2 * s);
         wr(ADDR_MODE_CTRL, {2'(s), 2'h0, 4'h9});
         repeat (k * dv - 2) @(posedge clk_sys);
         wr(ADDR_MODE_CTRL, {2'(s), 2'h0, 4'h0});
         rd(ADDR_COUNT);
         cmp_reg(rd_v, 8'(k));
      end
      // Capture on a rising, then a falling edge.
      for (int m = 1; m < 3; m++) begin
         wr(ADDR_MODE_CTRL, {2'h3, 2'(m), 4'hF});
         md = m;
         cnt = 0;
         lf = lfsr(lf);
         run(lf[5:0] + 1);
         @(posedge clk_sys);
         capture_edge_input <= (m == 1);
         repeat (8) @(posedge clk_sys);
         rd(ADDR_CMP_CAP);
         cmp_reg(rd_v, 8'(cnt));
         cmp_pin(match_capture_interrupt, 1'b1);
      end
      // Pulse mode, run past a wrap.
      lf = lfsr(lf);
      rv = lf[7:0];
      wr(ADDR_CMP_CAP, 8'(rv));
      wr(ADDR_MODE_CTRL, 8'hFF);
      md = 3;
      cnt = 0;
      pend = 0;
      repeat (3) begin
         lf = lfsr(lf);
         run(lf[6:0] + 90);
         rd(ADDR_COUNT);
         cmp_reg(rd_v, 8'(cnt));
         cmp_pin(pulse_mod_output, rv > cnt);
         cmp_pin(count_wrap_interrupt, pend[1]);
      end
      report_and_stop;
   end
endmodule
`default_nettype wire

// ### dv/ext_pulse_source.sv
// External count clock source that idles low between bursts.
`timescale 1ns/1ns
`default_nettype none
module ext_pulse_source (
   input wire logic clk_sys,
   output logic ext_clk
);
   int half = 6;
   initial ext_clk = 1'b0;
   // Bursts of n pulses; the half period is slow enough for the pin synchroniser.
   task automatic pulses(input int n);
      repeat (n) begin
         repeat (half) @(posedge clk_sys);
         ext_clk <= 1'b1;
         repeat (half) @(posedge clk_sys);
         ext_clk <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ### dv/timer8_properties.sv
// Checker of the timer core's port behaviour, bound to the core.
`timescale 1ns/1ns
`default_nettype none
module timer8_properties
   import timer8_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic compare_toggle_output,
   input wire logic pulse_mod_output,
   input wire logic count_wrap_interrupt,
   input wire logic match_capture_interrupt,
   input wire logic [7:0] ovf_vector
);
   logic [7:0] ctrl_r;
   logic ctl_wr;
   logic pnd_wr;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // Write strobes of the control and pending registers.
   assign ctl_wr = reg_wr && reg_addr == ADDR_MODE_CTRL;
   assign pnd_wr = reg_wr && reg_addr == ADDR_IRQ_PEND;
   // Shadow of the control register; the clear command reads back as zero.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= MODE_CTRL_RST;
      end else if (ctl_wr) begin
         ctrl_r <= reg_wdata & 8'hF7;
      end
   end
   ////////////////////////////////////////
   // Relations between the register port, the pins and the requests.
   chk_vector_zero: assert property (ovf_vector == OVF_VECTOR)
      else $error("overflow vector wrong");
   chk_mc_mask: assert property (match_capture_interrupt |-> ctrl_r[BIT_MC_IE])
      else $error("match request while disabled");
   chk_wrap_mask: assert property (count_wrap_interrupt |-> ctrl_r[BIT_OVF_IE])
      else $error("wrap request while disabled");
   chk_ctrl_read: assert property (reg_rd && !reg_wr && reg_addr == ADDR_MODE_CTRL
      |=> reg_rdata == $past(ctrl_r))
      else $error("control readback wrong");
   chk_unmapped_read: assert property (reg_rd && (reg_addr < ADDR_MODE_CTRL || reg_addr > ADDR_IRQ_PEND)
      |=> reg_rdata == ZERO8) else $error("unmapped read not zero");
   chk_mc_hold: assert property (match_capture_interrupt && !ctl_wr && !pnd_wr |=> match_capture_interrupt)
      else $error("match request dropped");
   chk_pwm_idle: assert property (ctrl_r[5:4] != MODE_PWM && $past(ctrl_r[5:4]) != MODE_PWM
      |-> !pulse_mod_output)
      else $error("pulse output high outside pulse mode");
   chk_toggle_irq: assert property ($changed(compare_toggle_output) && ctrl_r[BIT_MC_IE]
      && $past(ctrl_r[BIT_MC_IE]) && ctrl_r[5:4] == MODE_INTERVAL |-> match_capture_interrupt)
      else $error("toggle without request");
endmodule
bind timer8 timer8_properties i_chk (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .compare_toggle_output, .pulse_mod_output, .count_wrap_interrupt, .match_capture_interrupt, .ovf_vector);
`default_nettype wire

// ### src/timer8.sv
// 8-bit timer/counter with interval, capture and pulse-width modes.
// Function
// RQ1 - Three modes chosen by control field
// RQ2 - Clock: sys/1024, /256, /64 or external
// RQ3 - Overflow and match/capture pending until cleared
// RQ4 - Interval match toggles pin, interrupts, clears
// RQ5 - PWM match never clears; counter wraps
// RQ6 - PWM low when reference <= counter
// RQ7 - PWM period is 256 counter clocks
// RQ8 - Capture edge loads counter into reference
// RQ9 - Software routes capture pin through port; here capture_edge_input is wired straight to the core, with no routing
// RQ10 - Capture: overflow and capture interrupts each
// RQ11 - Reset clears control to zero
// RQ12 - Control bit 3 clears the counter
// RQ13 - Control bit 0 starts the counter
// RQ14 - Control bit 1 enables match interrupt
// RQ15 - Overflow interrupt vector is 00H
// RQ16 - Writing zero clears a pending bit
// RQ17 - Bits 3 and 0 together restart cleanly
// RQ18 - Control register at F3H, read/write
// RQ19 - Counter steps per active edge, holds stopped
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////

// Three-stage synchroniser with a debounced level and edge pulses.
module pin_sync (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic pin,
   output logic rise,
   output logic fall
);

   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic level_r;

   // The pin passes three flip-flops; the first feeds only the second.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // A change counts only once the second and third stages agree.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         level_r <= 1'b0;
      end else if (s2_r == s3_r) begin
         level_r <= s3_r;
      end
   end

   // Each edge pulse lasts one cycle, until the held level catches up.
   assign rise = (s2_r == s3_r) && s3_r && !level_r;
   assign fall = (s2_r == s3_r) && !s3_r && level_r;

endmodule

////////////////////////////////////////////////////////////////////////////////

// Timer core with its register port.
module timer8
   import timer8_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic external_count_clock,
   input wire logic capture_edge_input,
   output logic compare_toggle_output,
   output logic pulse_mod_output,
   output logic count_wrap_interrupt,
   output logic match_capture_interrupt,
   output logic [7:0] ovf_vector
);

   logic [7:0] ctrl_r;
   logic [7:0] cmp_r;
   logic [7:0] cnt_r;
   logic [1:0] pend_r;
   logic [DIV_W-1:0] div_r;
   logic toggle_r;
   logic pwm_r;
   logic [7:0] rdata_r;

   logic ext_rise;
   logic cap_rise;
   logic cap_fall;
   logic [1:0] mode;
   logic [1:0] clksel;
   logic running;
   logic tick;
   logic wr_ctrl;
   logic wr_cmp;
   logic wr_pend;
   logic clear_req;
   logic capture_mode;
   logic cap_edge;
   logic match_hit;
   logic match_ev;
   logic wrap_ev;
   logic cap_ev;

   ////////////////////////////////////////////////////////////////////////////

   // External clock and capture pins come from outside the clock domain.
   pin_sync ext_sync (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .pin(external_count_clock),
      .rise(ext_rise),
      .fall()
   );

   pin_sync cap_sync (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .pin(capture_edge_input),
      .rise(cap_rise),
      .fall(cap_fall)
   );

   ////////////////////////////////////////////////////////////////////////////

   // Register port decode; a write lands on the same edge as its strobe.
   // The count address takes no writes; the counter is read-only here.
   assign wr_ctrl = reg_wr && (reg_addr == ADDR_MODE_CTRL); // RQ18
   assign wr_cmp = reg_wr && (reg_addr == ADDR_CMP_CAP);
   assign wr_pend = reg_wr && (reg_addr == ADDR_IRQ_PEND);
   assign clear_req = wr_ctrl && reg_wdata[BIT_CLEAR]; // RQ12

   // Control fields as currently stored.
   assign mode = ctrl_r[MODE_LO +: 2]; // RQ1
   assign clksel = ctrl_r[CLKSEL_LO +: 2];
   assign running = ctrl_r[BIT_START]; // RQ13
   assign capture_mode = (mode == MODE_CAP_RISE) || (mode == MODE_CAP_FALL);

   // Control register; the clear bit is a command and is never stored.
   // Every other bit reads back exactly as it was written.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= MODE_CTRL_RST; // RQ11
      end else if (wr_ctrl) begin
         ctrl_r <= reg_wdata & ~(ONE8 << BIT_CLEAR); // RQ18
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   // Free-running prescaler; the taps give one-cycle enables at each rate.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 1'b1;
      end
   end

   // Select the counter clock enable.
   // The divider is never cleared, so the first step after a start may come early.
   always_comb begin
      case (clksel) // RQ2
         CLK_DIV1024: tick = (div_r == DIV_LAST_1024);
         CLK_DIV256: tick = (div_r[7:0] == DIV_LAST_256);
         CLK_DIV64: tick = (div_r[5:0] == DIV_LAST_64);
         CLK_EXT: tick = ext_rise;
         default: tick = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////

   // Events of the counting logic.
   // A clear command in the same cycle suppresses the match and wrap events, but not a capture.
   assign match_hit = (cnt_r == cmp_r);
   assign match_ev = running && tick && match_hit && !capture_mode && !clear_req; // RQ4
   assign wrap_ev = running && tick && (cnt_r == COUNT_MAX) && !clear_req
                    && !((mode == MODE_INTERVAL) && match_hit);
   assign cap_edge = (mode == MODE_CAP_RISE) ? cap_rise : cap_fall; // RQ8
   assign cap_ev = capture_mode && cap_edge;

   // The counter steps on each enable while started and holds when stopped.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= COUNT_RST;
      end else if (clear_req) begin
         cnt_r <= ZERO8; // RQ12
      end else if (running && tick) begin // RQ19
         if ((mode == MODE_INTERVAL) && match_hit) begin
            cnt_r <= ZERO8; // RQ4
         end else begin
            cnt_r <= cnt_r + ONE8; // RQ5
         end
      end
   end

   // Reference value: software writes it and a capture edge loads it.
   // A capture edge wins over a software write that lands in the same cycle.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cmp_r <= CMP_CAP_RST;
      end else if (cap_ev) begin
         cmp_r <= cnt_r; // RQ8
      end else if (wr_cmp) begin
         cmp_r <= reg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   // Pending flags: hardware set wins over a software clear in one cycle.
   // The clear command empties both flags unless an event sets them at once.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pend_r <= 2'b00;
      end else begin
         if (match_ev || cap_ev) begin
            pend_r[PEND_MC] <= 1'b1; // RQ3 RQ10
         end else if (clear_req) begin
            pend_r[PEND_MC] <= 1'b0; // RQ17
         end else if (wr_pend && !reg_wdata[PEND_MC]) begin
            pend_r[PEND_MC] <= 1'b0; // RQ16
         end
         if (wrap_ev) begin
            pend_r[PEND_OVF] <= 1'b1; // RQ3 RQ10
         end else if (clear_req) begin
            pend_r[PEND_OVF] <= 1'b0; // RQ17
         end else if (wr_pend && !reg_wdata[PEND_OVF]) begin
            pend_r[PEND_OVF] <= 1'b0; // RQ16
         end
      end
   end

   // Requests are pending flags gated by their enables.
   // Dropping an enable hides the request but leaves the flag pending.
   assign match_capture_interrupt = pend_r[PEND_MC] && ctrl_r[BIT_MC_IE]; // RQ14
   assign count_wrap_interrupt = pend_r[PEND_OVF] && ctrl_r[BIT_OVF_IE]; // RQ3
   assign ovf_vector = OVF_VECTOR; // RQ15

   ////////////////////////////////////////////////////////////////////////////

   // Interval output flips on every match.
   // The pin keeps its level when the mode leaves interval timing.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         toggle_r <= 1'b0;
      end else if (match_ev && (mode == MODE_INTERVAL)) begin
         toggle_r <= ~toggle_r; // RQ4
      end
   end

   // Pulse output follows the comparison; one period spans 256 counts.
   // The compare sees the count before its step, so the pin lags by one cycle.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pwm_r <= 1'b0;
      end else if (mode == MODE_PWM) begin
         pwm_r <= (cmp_r > cnt_r); // RQ6 RQ7
      end else begin
         pwm_r <= 1'b0;
      end
   end

   // Both output pins come straight from flip-flops.
   assign compare_toggle_output = toggle_r;
   assign pulse_mod_output = pwm_r;

   ////////////////////////////////////////////////////////////////////////////

   // Read data is registered one cycle after the read strobe.
   // Unmapped addresses read as zero rather than holding stale data.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rdata_r <= ZERO8;
      end else if (reg_rd) begin
         case (reg_addr)
            ADDR_MODE_CTRL: rdata_r <= ctrl_r; // RQ18
            ADDR_CMP_CAP: rdata_r <= cmp_r;
            ADDR_COUNT: rdata_r <= cnt_r;
            ADDR_IRQ_PEND: rdata_r <= {6'h00, pend_r};
            default: rdata_r <= ZERO8;
         endcase
      end
   end

   assign reg_rdata = rdata_r;

endmodule

`default_nettype wire

// ### src/timer8_pkg.sv
// Package of register addresses, field positions and constants for the 8-bit timer.
package timer8_pkg;

   // Register addresses on the register port.
   localparam logic [7:0] ADDR_MODE_CTRL = 8'hF3;
   localparam logic [7:0] ADDR_CMP_CAP = 8'hF4;
   localparam logic [7:0] ADDR_COUNT = 8'hF5;
   localparam logic [7:0] ADDR_IRQ_PEND = 8'hF6;

   // Reset values and other byte constants.
   localparam logic [7:0] MODE_CTRL_RST = 8'h00;
   localparam logic [7:0] CMP_CAP_RST = 8'hFF;
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [7:0] ONE8 = 8'h01;
   localparam logic [7:0] COUNT_MAX = 8'hFF;

   // Field positions of the mode control register.
   localparam int BIT_START = 0;
   localparam int BIT_MC_IE = 1;
   localparam int BIT_OVF_IE = 2;
   localparam int BIT_CLEAR = 3;
   localparam int MODE_LO = 4;
   localparam int CLKSEL_LO = 6;

   // Field positions of the pending register.
   localparam int PEND_MC = 0;
   localparam int PEND_OVF = 1;

   // Vector address of the overflow interrupt.
   localparam logic [7:0] OVF_VECTOR = 8'h00;

   // Operating modes.
   localparam logic [1:0] MODE_INTERVAL = 2'h0;
   localparam logic [1:0] MODE_CAP_RISE = 2'h1;
   localparam logic [1:0] MODE_CAP_FALL = 2'h2;
   localparam logic [1:0] MODE_PWM = 2'h3;

   // Counter clock selections.
   localparam logic [1:0] CLK_DIV1024 = 2'h0;
   localparam logic [1:0] CLK_DIV256 = 2'h1;
   localparam logic [1:0] CLK_DIV64 = 2'h2;
   localparam logic [1:0] CLK_EXT = 2'h3;

   // Prescaler taps: the divider wraps every 1024 cycles, taps mark 256 and 64.
   localparam int DIV_W = 10;
   localparam logic [9:0] DIV_LAST_1024 = 10'h3FF;
   localparam logic [7:0] DIV_LAST_256 = 8'hFF;
   localparam logic [5:0] DIV_LAST_64 = 6'h3F;

endpackage
